// ### hw/mcu_core_pkg.sv
// shared constants, types and decode functions for the small 8-bit core
`default_nettype none

package mcu_core_pkg;

  // data-space map of the registers that live in ram
  localparam logic [7:0] ACC_ADDR = 8'hff;
  localparam logic [7:0] FIRST_PTR_ADDR = 8'h80;
  localparam logic [7:0] SECOND_PTR_ADDR = 8'h81;

  // program-space vectors (reset start, external and timer interrupts)
  localparam logic [11:0] RESET_VECTOR = 12'h000;
  localparam logic [11:0] EXT_IRQ_VECTOR = 12'hffc;
  localparam logic [11:0] TIMER_IRQ_VECTOR = 12'hff8;

  // inherent opcodes, the three-byte move and extended-address upper nibbles
  localparam logic [7:0] OP_MVI = 8'hb0;
  localparam logic [7:0] OP_RTI = 8'hb2;
  localparam logic [7:0] OP_RTS = 8'hb3;
  localparam logic [7:0] OP_COMA = 8'hb4;
  localparam logic [7:0] OP_ROLA = 8'hb5;
  localparam logic [7:0] OP_STOP = 8'hb6;
  localparam logic [7:0] OP_WAIT = 8'hb7;
  localparam logic [3:0] OP_JSR_HI = 4'h8;
  localparam logic [3:0] OP_JMP_HI = 4'h9;

  // timer control/status field positions and reset values
  localparam int TIMER_CTRL_STATUS_REG_PRESCALE_BIT = 5;
  localparam int TIMER_CTRL_STATUS_REG_IRQ_EN_BIT = 6;
  localparam int TIMER_CTRL_STATUS_REG_ZERO_BIT = 7;
  localparam logic [7:0] TIMER_CTRL_STATUS_REG_WRITE_MASK = 8'he0;
  localparam logic [7:0] TIMER_CTRL_STATUS_REG_RESET = 8'h00;
  localparam logic [7:0] TIMER_RELOAD_RESET = 8'hff;

  // apb register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TIMER_CTRL_STATUS = 8'h08;
  localparam logic [7:0] REG_TIMER_RELOAD = 8'h0c;
  localparam logic [7:0] REG_TIMER_COUNT = 8'h10;

  // timing: oscillator-stabilisation delay after stop, in oscillator periods
  localparam int CLK_PERIOD_NS = 20;
  localparam int OSC_PERIOD_NS = 20;
  localparam int STOP_WAKE_PERIODS = 1920;
  localparam int WAKE_CYCLES = STOP_WAKE_PERIODS * OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [2:0] CYC_SHORT = 3'd2;
  localparam logic [2:0] CYC_STD = 3'd4;
  localparam logic [2:0] CYC_BIT_BRANCH = 3'd5;
  localparam int STACK_DEPTH_DEFAULT = 4;

  // power modes of the core
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_WAIT = 2'b01,
    MODE_STOP = 2'b10,
    MODE_WAKE = 2'b11
  } power_mode_t;

  // total cycle count of an opcode
  function automatic logic [2:0] op_cycles(input logic [7:0] op);
    if (!op[7] || op == OP_RTI || op == OP_RTS || op == OP_STOP || op == OP_WAIT)
      return CYC_SHORT;
    if (op[7:4] == 4'hc)
      return CYC_BIT_BRANCH;
    if (op[7:3] == 5'b10100 || op == 8'hb1 || op == 8'he9 || op == 8'hee || op == 8'hef)
      return CYC_SHORT;
    return CYC_STD;
  endfunction

  // byte length of an opcode
  function automatic logic [11:0] op_length(input logic [7:0] op);
    if (op == OP_MVI || op[7:4] == 4'hc)
      return 12'd3;
    if (op[7:5] == 3'b100 || op[7:4] == 4'hd || op[7:3] == 5'b11101 || op[7:3] == 5'b11111)
      return 12'd2;
    return 12'd1;
  endfunction

endpackage

`default_nettype wire

// ### hw/data_space_ram.sv
// data-space ram with one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none

module data_space_ram #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  // read ports
  input wire logic [ADDR_W-1:0] rd_addr_a_i,
  input wire logic [ADDR_W-1:0] rd_addr_b_i,
  output logic [DATA_W-1:0] rd_data_a_o,
  output logic [DATA_W-1:0] rd_data_b_o
);

  // read registers form the module state
  typedef struct packed {
    logic [DATA_W-1:0] rd_a;
    logic [DATA_W-1:0] rd_b;
  } ram_state_t;

  logic [DATA_W-1:0] mem [2**ADDR_W]; // storage array, not reset
  ram_state_t st; // registered state
  ram_state_t next_st; // next state

  // refuse widths the storage cannot serve
  if (ADDR_W < 1 || ADDR_W > 12 || DATA_W < 1)
    $error("data_space_ram: unsupported width");

  // array write, separate from the state registers
  always_ff @(posedge clk_sys_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // read data of this cycle's addresses
  always_comb
  begin
    next_st = st;
    next_st.rd_a = mem[rd_addr_a_i];
    next_st.rd_b = mem[rd_addr_b_i];
  end

  // register the read data
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign rd_data_a_o = st.rd_a;
  assign rd_data_b_o = st.rd_b;

endmodule

`default_nettype wire

// ### hw/mcu_opcode_decode_and_lowpower.sv
// 8-bit core sequencer: opcode decode, execution, timer, stop/wait, apb view
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module mcu_opcode_decode_and_lowpower
  import mcu_core_pkg::*;
#(
  parameter int STACK_DEPTH = mcu_core_pkg::STACK_DEPTH_DEFAULT
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // program memory, combinational read
  output logic [11:0] prog_addr_o,
  input wire logic [7:0] prog_data_i,
  // interrupt request pin, active low
  input wire logic interrupt_request_input_n_i,
  // power control
  output logic osc_enable_o,
  output logic core_clk_en_o
);
  import mcu_core_pkg::*;

  localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  // refuse stack depths the pointer cannot wrap over
  if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0)
    $error("stack depth must be a power of two, at least 2");
  if (WAKE_CYCLES < 1 || WAKE_CYCLES > 2047)
    $error("wake delay does not fit its counter");

  // complete register state of the core
  typedef struct packed {
    logic ctrl_run; // software run enable
    power_mode_t mode; // power mode
    logic [11:0] pc; // program counter
    logic [7:0] op; // current opcode
    logic [7:0] b1; // second instruction byte
    logic [7:0] b2; // third instruction byte
    logic [7:0] ea; // effective data address
    logic [2:0] cyc; // cycle within instruction
    logic z; // zero flag
    logic c; // carry flag
    logic int_mask; // set while an interrupt is serviced
    logic [STACK_DEPTH-1:0][13:0] stack; // {z, c, pc} entries
    logic [SP_W-1:0] sp; // stack pointer
    logic [7:0] timer_ctrl_status_reg; // timer_ctrl_status_reg
    logic [7:0] treload; // timer reload value
    logic [7:0] tcount; // timer down counter
    logic [10:0] wake_cnt; // oscillator stabilisation counter
    logic [31:0] prdata; // apb read data
    logic pslverr; // apb error for the current transfer
    logic irq_s1; // irq synchroniser, first stage
    logic irq_s2; // irq synchroniser, second stage
  } core_state_t;

  core_state_t st; // registered state
  core_state_t next_st; // next state

  logic [7:0] rd_addr_a, rd_addr_b; // ram read addresses
  logic [7:0] rd_data_a, rd_data_b; // ram read data
  logic mem_we; // ram write enable
  logic [7:0] mem_waddr, mem_wdata; // ram write address and data
  logic exec_on; // core advancing this cycle
  logic ext_pending; // synchronised external request
  logic timer_irq; // enabled timer request
  logic take_irq; // interrupt entry instead of fetch
  logic fetch; // opcode fetched this cycle
  logic branch_cond; // relative branch condition true
  logic [11:0] rel_target; // relative branch target
  logic [7:0] acc_val, opd; // accumulator and operand at execute
  logic [8:0] wide; // alu result with carry/borrow
  logic [2:0] func; // unified alu function
  logic is_alu; // alu or short-direct class
  logic bit_tested; // bit examined by bit-test-branch
  logic reg_lower; // register below operand
  logic [SP_W-1:0] sp_pop; // index of top stack entry

  // data-space memory holding ram, accumulator and pointers
  data_space_ram #(.ADDR_W(8), .DATA_W(8)) u_ram (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(mem_we),
    .wr_addr_i(mem_waddr),
    .wr_data_i(mem_wdata),
    .rd_addr_a_i(rd_addr_a),
    .rd_addr_b_i(rd_addr_b),
    .rd_data_a_o(rd_data_a),
    .rd_data_b_o(rd_data_b)
  );

  // decode helpers shared by execution and checks
  assign ext_pending = !st.irq_s2;
  assign timer_irq = st.timer_ctrl_status_reg[TIMER_CTRL_STATUS_REG_IRQ_EN_BIT] & st.timer_ctrl_status_reg[TIMER_CTRL_STATUS_REG_ZERO_BIT];
  assign exec_on = st.ctrl_run && st.mode == MODE_RUN;
  assign take_irq = exec_on && st.cyc == 3'd0 && !st.int_mask && (ext_pending || timer_irq);
  assign fetch = exec_on && st.cyc == 3'd0 && !take_irq;
  assign rel_target = st.pc + 12'd1 + {{7{st.op[4]}}, st.op[4:0]};
  assign sp_pop = st.sp - SP_W'(1);
  assign acc_val = rd_data_b;
  assign opd = (st.op[7:3] == 5'b11101) ? st.b1 : rd_data_a;
  assign bit_tested = rd_data_a[st.op[2:0]];
  assign reg_lower = acc_val < opd;
  assign is_alu = st.op[7:5] == 3'b111 || st.op[7:4] == 4'ha || st.op[7:3] == 5'b10111;

  // condition chosen by 32-opcode block
  always_comb
  begin
    case (st.op[6:5])
      2'b00: branch_cond = !st.z;
      2'b01: branch_cond = st.z;
      2'b10: branch_cond = !st.c;
      default: branch_cond = st.c;
    endcase
  end

  // short-direct opcodes map onto the alu function codes
  always_comb
  begin
    if (st.op[7:5] == 3'b111)
      func = st.op[2:0];
    else
      func = {st.op[2] ? 2'b00 : 2'b11, st.op[4]};
  end

  // next-state logic: apb, timer, power modes, instruction sequencer
  always_comb
  begin
    next_st = st;
    mem_we = 1'b0;
    mem_waddr = st.ea;
    mem_wdata = 8'h00;
    rd_addr_a = st.ea;
    rd_addr_b = ACC_ADDR;
    wide = 9'h000;
    // two-flop synchroniser for the irq pin
    next_st.irq_s1 = interrupt_request_input_n_i;
    next_st.irq_s2 = st.irq_s1;
    // apb setup phase: register read data and decode error
    if (psel_i && !penable_i)
    begin
      next_st.pslverr = 1'b0;
      case (paddr_i)
        REG_CTRL: next_st.prdata = {31'h0, st.ctrl_run};
        REG_STATUS: next_st.prdata = {13'h0, st.ctrl_run, st.mode, 1'b0, st.int_mask,
                                      st.c, st.z, st.pc};
        REG_TIMER_CTRL_STATUS: next_st.prdata = {24'h0, st.timer_ctrl_status_reg};
        REG_TIMER_RELOAD: next_st.prdata = {24'h0, st.treload};
        REG_TIMER_COUNT: next_st.prdata = {24'h0, st.tcount};
        default:
        begin
          next_st.prdata = 32'h0;
          next_st.pslverr = 1'b1;
        end
      endcase
    end
    // apb access phase: writes
    if (psel_i && penable_i && pwrite_i)
    begin
      case (paddr_i)
        REG_CTRL: next_st.ctrl_run = pwdata_i[0];
        REG_TIMER_CTRL_STATUS: next_st.timer_ctrl_status_reg = pwdata_i[7:0] & TIMER_CTRL_STATUS_REG_WRITE_MASK;
        REG_TIMER_RELOAD: next_st.treload = pwdata_i[7:0];
        default: ;
      endcase
    end
    // timer: runs with the core, in wait only when prescale control is set
    if (st.mode == MODE_RUN || (st.mode == MODE_WAIT && st.timer_ctrl_status_reg[TIMER_CTRL_STATUS_REG_PRESCALE_BIT]))
    begin
      if (st.tcount == 8'h00)
      begin
        next_st.tcount = st.treload;
        next_st.timer_ctrl_status_reg[TIMER_CTRL_STATUS_REG_ZERO_BIT] = 1'b1; // set wins over software clear
      end
      else
        next_st.tcount = st.tcount - 8'h01;
    end
    // low-power modes: only wake-up logic advances, and the timer in wait when prescale control is set
    case (st.mode)
      MODE_WAIT:
      begin
        if (ext_pending || timer_irq)
          next_st.mode = MODE_RUN;
      end
      MODE_STOP:
      begin
        // oscillator off: timer, core and state held unchanged
        if (ext_pending)
        begin
          next_st.mode = MODE_WAKE;
          next_st.wake_cnt = 11'(WAKE_CYCLES - 1);
        end
      end
      MODE_WAKE:
      begin
        // oscillator stabilising before processing resumes
        if (st.wake_cnt == 11'd0)
          next_st.mode = MODE_RUN;
        else
          next_st.wake_cnt = st.wake_cnt - 11'd1;
      end
      default: ;
    endcase
    // instruction sequencer
    if (take_irq)
    begin
      // interrupt entry pushes flags and return address
      next_st.stack[st.sp] = {st.z, st.c, st.pc};
      next_st.sp = st.sp + SP_W'(1);
      next_st.pc = ext_pending ? EXT_IRQ_VECTOR : TIMER_IRQ_VECTOR;
      next_st.int_mask = 1'b1;
    end
    else if (fetch)
    begin
      next_st.op = prog_data_i;
      next_st.cyc = 3'd1;
    end
    else if (exec_on)
    begin
      next_st.cyc = (st.cyc == op_cycles(st.op) - 3'd1) ? 3'd0 : st.cyc + 3'd1;
      case (st.cyc)
        3'd1:
        begin
          next_st.b1 = prog_data_i;
          rd_addr_b = st.op[4] ? SECOND_PTR_ADDR : FIRST_PTR_ADDR;
          if (op_cycles(st.op) == CYC_SHORT)
          begin
            next_st.pc = st.pc + 12'd1;
            if (!st.op[7])
              next_st.pc = branch_cond ? rel_target : st.pc + 12'd1;
            else if (st.op == OP_RTS || st.op == OP_RTI)
            begin
              next_st.sp = sp_pop;
              next_st.pc = st.stack[sp_pop][11:0];
              if (st.op == OP_RTI)
              begin
                next_st.z = st.stack[sp_pop][13];
                next_st.c = st.stack[sp_pop][12];
                next_st.int_mask = 1'b0;
              end
            end
            else if (st.op == OP_STOP)
            begin
              next_st.mode = MODE_STOP;
              next_st.timer_ctrl_status_reg[TIMER_CTRL_STATUS_REG_IRQ_EN_BIT] = 1'b0;
              next_st.timer_ctrl_status_reg[TIMER_CTRL_STATUS_REG_ZERO_BIT] = 1'b0;
            end
            else if (st.op == OP_WAIT)
              next_st.mode = MODE_WAIT;
          end
        end
        3'd2:
        begin
          next_st.b2 = prog_data_i;
          // effective address by addressing mode
          if (st.op[7:5] == 3'b111 && !st.op[3])
            next_st.ea = rd_data_b;
          else if (st.op[7:4] == 4'ha || st.op[7:4] == 4'hb)
            next_st.ea = FIRST_PTR_ADDR | {6'h0, st.op[1:0]};
          else
            next_st.ea = st.b1;
          rd_addr_a = next_st.ea;
          rd_addr_b = ACC_ADDR;
        end
        3'd3:
        begin
          next_st.pc = st.pc + op_length(st.op);
          if (st.op[7:4] == OP_JSR_HI || st.op[7:4] == OP_JMP_HI)
          begin
            next_st.pc = {st.op[3:0], st.b1};
            if (st.op[7:4] == OP_JSR_HI)
            begin
              next_st.stack[st.sp] = {st.z, st.c, st.pc + 12'd2};
              next_st.sp = st.sp + SP_W'(1);
            end
          end
          else if (st.op[7:4] == 4'hc)
          begin
            next_st.c = bit_tested;
            if (bit_tested == st.op[3])
              next_st.pc = st.pc + 12'd3 + {{4{st.b2[7]}}, st.b2};
          end
          else if (st.op[7:4] == 4'hd)
          begin
            mem_we = 1'b1;
            mem_waddr = st.ea;
            mem_wdata = rd_data_a;
            mem_wdata[st.op[2:0]] = st.op[3];
          end
          else if (st.op == OP_MVI)
          begin
            mem_we = 1'b1;
            mem_waddr = st.b1;
            mem_wdata = st.b2;
          end
          else if (st.op == OP_COMA || st.op == OP_ROLA)
          begin
            mem_we = 1'b1;
            mem_waddr = ACC_ADDR;
            mem_wdata = (st.op == OP_COMA) ? ~acc_val : {acc_val[6:0], st.c};
            next_st.c = (st.op == OP_COMA) ? 1'b1 : acc_val[7];
            next_st.z = mem_wdata == 8'h00;
          end
          else if (is_alu)
          begin
            // accumulator/memory operations with their flag updates
            mem_we = 1'b1;
            mem_waddr = ACC_ADDR;
            case (func)
              3'd0: mem_wdata = opd;
              3'd1:
              begin
                mem_waddr = st.ea;
                mem_wdata = acc_val;
              end
              3'd2:
              begin
                wide = {1'b0, acc_val} + {1'b0, opd};
                mem_wdata = wide[7:0];
                next_st.c = wide[8];
              end
              3'd3, 3'd4:
              begin
                wide = {1'b0, acc_val} - {1'b0, opd};
                mem_we = (func == 3'd3);
                mem_wdata = wide[7:0];
                next_st.c = reg_lower;
              end
              3'd5: mem_wdata = acc_val & opd;
              3'd6:
              begin
                mem_waddr = st.ea;
                mem_wdata = opd + 8'h01;
              end
              default:
              begin
                mem_waddr = st.ea;
                mem_wdata = opd - 8'h01;
              end
            endcase
            next_st.z = mem_wdata == 8'h00;
          end
        end
        default: ;
      endcase
    end
  end

  // state register with asynchronous reset to constants
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st <= '0;
      st.pc <= RESET_VECTOR;
      st.timer_ctrl_status_reg <= TIMER_CTRL_STATUS_REG_RESET;
      st.treload <= TIMER_RELOAD_RESET;
      st.tcount <= TIMER_RELOAD_RESET;
      st.irq_s1 <= 1'b1;
      st.irq_s2 <= 1'b1;
    end
    else
      st <= next_st;
  end

  // outputs
  assign prdata_o = st.prdata;
  assign pready_o = 1'b1;
  assign pslverr_o = st.pslverr;
  assign prog_addr_o = st.pc + {9'h000, st.cyc};
  assign osc_enable_o = st.mode != MODE_STOP;
  assign core_clk_en_o = st.mode == MODE_RUN;

  // checks
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence four_steps;
    st.cyc == 3'd1 ##1 st.cyc == 3'd2 ##1 st.cyc == 3'd3 ##1 st.cyc == 3'd0;
  endsequence
  sequence five_steps;
    st.cyc == 3'd1 ##1 st.cyc == 3'd2 ##1 st.cyc == 3'd3 ##1 st.cyc == 3'd4 ##1 st.cyc == 3'd0;
  endsequence

  a_branch_two_cycles: assert property (
    fetch && !prog_data_i[7] |=> st.cyc == 3'd1 ##1 st.cyc == 3'd0)
    else $error("branch did not take two cycles");
  a_short_inc_rmw: assert property (
    fetch && prog_data_i[7:2] == 6'b101010 |=> four_steps)
    else $error("short increment did not take four cycles");
  a_short_dec_rmw: assert property (
    fetch && prog_data_i[7:2] == 6'b101110 |=> four_steps)
    else $error("short decrement did not take four cycles");
  a_bit_branch_cycles: assert property (
    fetch && prog_data_i[7:4] == 4'hc |=> five_steps)
    else $error("bit-test-branch did not take five cycles");
  a_rel_branch_target: assert property (
    exec_on && st.cyc == 3'd1 && !st.op[7] && branch_cond |=> st.pc == $past(rel_target))
    else $error("taken branch went to wrong target");
  a_nop_next_addr: assert property (
    exec_on && st.cyc == 3'd1 && st.op == 8'h20 |=> st.pc == $past(st.pc) + 12'd1)
    else $error("no-operation did not advance by one");
  a_stop_timer_clear: assert property (
    exec_on && st.cyc == 3'd1 && st.op == OP_STOP
    |=> st.mode == MODE_STOP && !st.timer_ctrl_status_reg[TIMER_CTRL_STATUS_REG_IRQ_EN_BIT] && !st.timer_ctrl_status_reg[TIMER_CTRL_STATUS_REG_ZERO_BIT])
    else $error("stop left timer irq bits set");
  // the timer may still step on the edge that enters stop, so hold is checked one cycle on
  a_stop_osc_off: assert property (
    st.mode == MODE_STOP |-> !osc_enable_o ##1 $stable(st.tcount))
    else $error("oscillator or timer running in stop");
  a_stop_wake_load: assert property (
    st.mode == MODE_STOP && ext_pending
    |=> st.mode == MODE_WAKE && st.wake_cnt == 11'(WAKE_CYCLES - 1))
    else $error("stop exit did not start the wake delay");
  a_wait_timer_exit: assert property (
    st.mode == MODE_WAIT && timer_irq |=> st.mode == MODE_RUN)
    else $error("enabled timer irq did not end wait");
  a_bit_to_carry: assert property (
    exec_on && st.cyc == 3'd3 && st.op[7:4] == 4'hc |=> st.c == $past(bit_tested))
    else $error("tested bit not copied to carry");
  a_cmp_carry: assert property (
    exec_on && st.cyc == 3'd3 && st.op[7:5] == 3'b111 && st.op[2:0] == 3'd4
    |=> st.c == $past(reg_lower))
    else $error("compare carry wrong");

endmodule

`default_nettype wire

// ### verification/prog_mem.sv
// program memory model answering the core's fetch address
`timescale 1ns/1ps
`default_nettype none
module prog_mem (
  // fetch port
  input wire logic [11:0] addr_i,
  output logic [7:0] data_o
);
  // program bytes, cleared here and loaded later by the bench
  logic [7:0] mem [4096];
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // combinational read in the same cycle as the address
  assign data_o = mem[addr_i];
endmodule
`default_nettype wire

// ### verification/mcu_opcode_decode_and_lowpower_tb_top.sv
// bench for the core sequencer: program run, apb view, wait and stop
`timescale 1ns/1ps
`default_nettype none
module mcu_opcode_decode_and_lowpower_tb_top;
  import mcu_core_pkg::*;
  logic clk_sys_i = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, irq_n = 1;
  logic [7:0] pa = 8'h00, pd;
  logic [31:0] pw = 32'h0, prd, rd;
  logic prdy, perr, osc, cen;
  logic [11:0] fa;
  int n_mismatch = 0, tests_run = 0, k;
  always #10 clk_sys_i = ~clk_sys_i;
  mcu_opcode_decode_and_lowpower i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(rst_n),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pw),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .prog_addr_o(fa),
    .prog_data_i(pd), .interrupt_request_input_n_i(irq_n), .osc_enable_o(osc),
    .core_clk_en_o(cen));
  prog_mem i_prog (.addr_i(fa), .data_o(pd));
  // verdict and end of run
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // compare one value against its expectation
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  // one apb transfer; read data taken at the pready edge, error checked by the caller on perr
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; pwr <= w; pa <= a; pw <= d;
    @(posedge clk_sys_i);
    pen <= 1;
    k = 0;
    do @(posedge clk_sys_i); while (prdy !== 1'b1 && ++k < 50);
    rd = prd;
    if (k >= 50) chk(0, 1, "apb timeout");
    if (k >= 50) summarize();
    psel <= 0; pen <= 0;
    @(posedge clk_sys_i);
  endtask
  // poll the status mode field under a bound
  task automatic poll_mode(input logic [1:0] m);
    for (int i = 0; i < 3000; i++)
    begin
      apb(0, REG_STATUS, 0);
      if (rd[17:16] === m) return;
    end
    chk(0, 1, "mode timeout");
    summarize();
  endtask
  // load n program bytes, first byte in the top of v
  task automatic ld(input logic [11:0] a, input logic [55:0] v, input int n);
    for (int i = 0; i < n; i++) i_prog.mem[a + i] = v[8 * (n - 1 - i) +: 8];
  endtask
  initial
  begin
    #1;
    // ram is not reset: the program clears the first pointer before stepping it
    ld(12'h000, 56'hb08000a8b820c8, 7);
    ld(12'h007, 56'h8000d880c88002, 7);
    ld(12'h010, 16'h9ff0, 2);
    ld(12'hff0, 8'hb7, 1);
    ld(12'hffc, 16'h9020, 2);
    ld(12'h020, 56'hb08200ba1eb6ac, 7);
    ld(12'h027, 32'hec02b77f, 4);
    repeat (10) @(posedge clk_sys_i);
    rst_n <= 1;
    @(posedge clk_sys_i);
    apb(0, 8'h14, 0);
    chk(perr, 1, "no error on unmapped read");
    chk(rd, 0, "unmapped read data");
    $display("test apb done");
    apb(1, REG_CTRL, 1);
    poll_mode(2'd1);
    chk(rd[13:12], 2'b11, "flags at wait");
    chk({osc, cen}, 2'b10, "clock gating in wait");
    irq_n <= 0;
    poll_mode(2'd0);
    apb(1, REG_TIMER_CTRL_STATUS, 32'h40);
    irq_n <= 1;
    $display("test wait done");
    poll_mode(2'd2);
    chk({osc, cen}, 2'b00, "clocks in stop");
    apb(0, REG_TIMER_CTRL_STATUS, 0);
    chk(rd, 0, "timer bits after stop");
    irq_n <= 0;
    for (k = 0; k < 3000 && cen !== 1'b1; k++) @(posedge clk_sys_i);
    chk(k >= 1920 && k <= 1925, 1, "wake delay");
    irq_n <= 1;
    chk(osc, 1, "oscillator after wake");
    // compare below (carry set), then a wait that only the enabled timer ends
    apb(1, REG_TIMER_CTRL_STATUS, 32'h60);
    repeat (300) @(posedge clk_sys_i);
    apb(0, REG_STATUS, 0);
    chk(rd[17:0], 18'h0602a, "pc and mode after wake");
    $display("test stop done");
    summarize();
  end
endmodule
`default_nettype wire
